// *** sim/cascaded_pi_motor_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module cascaded_pi_motor_control_bench;
  localparam logic [7:0]  KP_CUR = 8'h60;
  localparam logic [7:0]  TN_CUR = 8'h64;
  localparam logic [7:0]  TN_VEL = 8'h54;
  localparam logic [15:0] MT [12] = '{16'h101F, 16'h601F, 16'h701F, 16'h801F, 16'hB01F,
    16'h201E, 16'h203F, 16'h301E, 16'h903F, 16'h401A, 16'h4218, 16'hA218};
  localparam logic [15:0] KP [6] = '{16'h03E8, 16'h03E8, 16'h01F4, 16'h03E8, 16'h03E8,
    16'h01F4};
  localparam logic [15:0] VF [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h03E8};
  localparam logic [31:0] ER [6] = '{32'h0000_1000, 32'h0000_0800, 32'h0000_0800,
    32'h0000_7000, 32'hFFFF_9000, 32'h0000_0800};
  localparam logic [31:0] EX [6] = '{32'h0000_1000, 32'h0000_0800, 32'h0000_0400,
    32'h0000_1000, 32'hFFFF_F000, 32'h0000_0600};
  logic               aclk = 1'b0;
  logic               aresetn = 1'b0;
  logic        [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic               awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic               engaged = 0, autoset_done = 0;
  logic        [31:0] wdata = 32'h0000_0000;
  logic signed [31:0] ramp_pos = 0, ramp_vel = 0, ramp_acc = 0, torque_target = 0;
  logic               awready, wready, bvalid, arready, rvalid, update_done;
  logic        [1:0]  bresp, rresp, r;
  logic        [31:0] rdata, d, v0;
  logic signed [31:0] pwm_demand, act_pos, act_vel, act_cur;
  int                 failures = 0, num_checks = 0, cyc = 0;

  always #10 aclk = ~aclk;

  cascade_ctrl cascade_ctrl_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .ramp_pos, .ramp_vel, .ramp_acc, .torque_target,
    .act_pos, .act_vel, .act_cur, .autoset_done, .pwm_demand, .update_done);
  motor_model motor_model_inst (.aclk, .aresetn, .engaged, .pwm_demand, .update_done,
    .act_pos, .act_vel, .act_cur);

  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dd, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= dd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    dd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic wrq(input logic [7:0] a, input logic [15:0] v);
    wr(a, {16'h0000, v}, r);
    chk("bresp", {30'h0, motor_pkg::RESP_OK}, {30'h0, r});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    rd(a, d, r);
    chk("rdata", {16'h0000, e}, d);
    chk("rresp", {30'h0, motor_pkg::RESP_OK}, {30'h0, r});
  endtask

  task automatic upd(output logic [31:0] p);
    do @(posedge aclk); while (update_done !== 1'b1);
    p = pwm_demand;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures = failures + 1;
      wrap_up();
    end
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(motor_pkg::A_SUBMODE, 16'h0000);
    rdchk(motor_pkg::A_PSEL, {14'h0, motor_pkg::RST_PSEL});
    rdchk(motor_pkg::A_VOLTFF, motor_pkg::RST_VOLTFF);
    rdchk(motor_pkg::A_INERTIA, motor_pkg::RST_INERTIA);
    rdchk(motor_pkg::A_RATEDV, motor_pkg::RST_RATEDV);
    rdchk(KP_CUR, motor_pkg::LEG_KP);
    rd(8'hFC, d, r);
    chk("rresp", {30'h0, motor_pkg::RESP_DEC}, {30'h0, r});
    chk("rdata", 32'h0000_0000, d);
    wr(8'hF8, 32'h0000_0001, r);
    chk("bresp", {30'h0, motor_pkg::RESP_DEC}, {30'h0, r});
    // open loop drives nothing even with a large torque demand
    torque_target <= 32'sh0000_4000;
    upd(v0);
    upd(v0);
    chk("pwm", 32'h0000_0000, v0);
    @(posedge aclk);
    autoset_done <= 1'b1;
    @(posedge aclk);
    autoset_done <= 1'b0;
    rdchk(motor_pkg::A_SUBMODE, 16'h0001);
    for (int i = 0; i < 12; i++) begin
      wrq(motor_pkg::A_MODE, {12'h000, MT[i][15:12]});
      wrq(motor_pkg::A_SUBMODE, {8'h00, MT[i][11:4]});
      upd(v0);
      rd(motor_pkg::A_STATUS, d, r);
      chk("status", {28'h0, MT[i][3:0]}, {28'h0, d[3:0]});
    end
    // real torque: only the current stage acts on torque_target
    upd(v0);
    wrq(motor_pkg::A_MODE, {12'h000, motor_pkg::M_PT});
    wrq(motor_pkg::A_SUBMODE, 16'h0021);
    wrq(motor_pkg::A_PSEL, 16'h0000);
    wrq(TN_CUR, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wrq(KP_CUR, KP[i]);
      wrq(motor_pkg::A_VOLTFF, VF[i]);
      torque_target <= ER[i];
      upd(v0);
      upd(d);
      chk("pwm", EX[i], v0);
      chk("pwm_next", EX[i], d);
    end
    wrq(TN_CUR, 16'h0004);
    upd(v0);
    upd(d);
    chk("integ", 32'h0000_0001, {31'h0, $signed(d) > $signed(v0)});
    // velocity and acceleration feed-forward into a still motor
    wrq(motor_pkg::A_MODE, {12'h000, motor_pkg::M_PV});
    wrq(motor_pkg::A_SUBMODE, 16'h0003);
    wrq(TN_VEL, 16'h0000);
    wrq(TN_CUR, 16'h0000);
    wrq(motor_pkg::A_VFF, 16'h01F4);
    wrq(motor_pkg::A_AFF, 16'h01F4);
    ramp_vel <= 32'sh0000_0400;
    ramp_acc <= 32'sh0000_0800;
    upd(v0);
    chk("pwm_ff", 32'h0000_0480, v0);
    // position mode with a moving motor stays within the pwm limit
    wrq(motor_pkg::A_MODE, {12'h000, motor_pkg::M_PP});
    wrq(motor_pkg::A_SUBMODE, 16'h0001);
    wrq(motor_pkg::A_PSEL, {14'h0, motor_pkg::RST_PSEL});
    engaged <= 1'b1;
    ramp_pos <= 32'sh0000_0100;
    ramp_vel <= 32'sh0000_0010;
    ramp_acc <= 32'sh0000_0004;
    for (int i = 0; i < 3; i++) begin
      upd(v0);
      chk("pwm_lim", 32'h0000_0001, {31'h0, $signed(v0) <= 32'sh1000 && $signed(v0) >= -32'sh1000});
    end
    wrap_up();
  end
endmodule
`default_nettype wire

// *** sim/motor_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module motor_model (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // drive side
  input  wire logic               engaged,
  input  wire logic signed [31:0] pwm_demand,
  input  wire logic               update_done,
  // encoder and current feedback
  output logic signed      [31:0] act_pos,
  output logic signed      [31:0] act_vel,
  output logic signed      [31:0] act_cur
);
  // current lags the demand by one update, the shaft integrates it
  always_ff @(posedge aclk) begin
    if (!aresetn || !engaged) begin
      act_pos <= 32'sh0000_0000;
      act_vel <= 32'sh0000_0000;
      act_cur <= 32'sh0000_0000;
    end else if (update_done) begin
      act_cur <= pwm_demand >>> 2;
      act_vel <= act_vel + (act_cur >>> 4);
      act_pos <= act_pos + (act_vel >>> 4);
    end
  end
endmodule
`default_nettype wire

// *** src/cascade_ctrl.sv ***
// Contract
// - three cascaded PI stages; each output is the next inner set point.
// - current stage runs in every operating mode.
// - velocity stage runs except in torque modes with submode bit 5 set.
// - position stage in position modes, and velocity modes when submode bit 1 set.
// - outputs clamp to max speed, max current and max PWM respectively.
// - at full gain a deviation of emax yields exactly ymax, linearly below.
// - proportional output scales linearly with the stage gain.
// - shorter reset time integrates faster; zero reset time disables integral.
// - legacy set is default; writing zero to its select picks the new set.
// - ramp velocity times feed-forward factor adds to position stage output.
// - velocity feed-forward only where the position stage is active.
// - acceleration times factor and inertia adds to velocity stage output.
// - acceleration feed-forward in all modes except torque modes.
// - voltage feed-forward adds to voltage demand, scaled per mille of rated.
// - voltage feed-forward always on, disabled when its factor is zero.
// - closed loop needs submode bit 0; auto setup completion sets it.
// - feed-forward values are injected in the same update they are computed.
// - submode bit 0 selects open loop at zero, closed loop at one.
`timescale 1ns/1ps
`default_nettype none
module cascade_ctrl (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite write
  input  wire logic        [7:0]  awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic        [31:0] wdata,
  input  wire logic        [3:0]  wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic             [1:0]  bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  // axi4-lite read
  input  wire logic        [7:0]  araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic             [31:0] rdata,
  output logic             [1:0]  rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // ramp generator and targets
  input  wire logic signed [31:0] ramp_pos,
  input  wire logic signed [31:0] ramp_vel,
  input  wire logic signed [31:0] ramp_acc,
  input  wire logic signed [31:0] torque_target,
  // feedback
  input  wire logic signed [31:0] act_pos,
  input  wire logic signed [31:0] act_vel,
  input  wire logic signed [31:0] act_cur,
  input  wire logic               autoset_done,
  // drive demand
  output logic signed      [31:0] pwm_demand,
  output logic                    update_done
);

  typedef struct packed {
    motor_pkg::seq_t          st;
    logic [11:0]              tmr;
    logic [7:0]               submode;
    logic [3:0]               op_mode;
    logic [1:0]               psel;
    logic [15:0]              vff_f;
    logic [15:0]              aff_f;
    logic [15:0]              inertia;
    logic [15:0]              volt_f;
    logic [15:0]              rated_v;
    logic [2:0][3:0][15:0]    prm;
    logic signed [31:0]       pwm;
    logic                     done;
    logic                     aw_got;
    logic                     w_got;
    logic [7:0]               awa;
    logic [31:0]              wd;
    logic [3:0]               ws;
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     arready;
    logic                     rvalid;
    logic [1:0]               rresp;
    logic [31:0]              rdata;
  } ctrl_state_t;

  ctrl_state_t              s;
  ctrl_state_t              next_s;
  logic                     closed;
  logic                     pos_en;
  logic                     vel_en;
  logic                     aff_en;
  logic                     tick;
  logic [2:0][3:0][15:0]    eff;
  logic [2:0]               start;
  logic [2:0]               clr;
  logic signed [2:0][31:0]  sp;
  logic signed [2:0][31:0]  act;
  logic signed [2:0][31:0]  y;
  logic signed [31:0]       vff_v;
  logic signed [31:0]       aff_v;
  logic signed [31:0]       volt_v;
  logic [31:0]              rd_val;
  logic                     rd_ok;
  logic [31:0]              wr_val;
  logic                     wr_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? d[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  function automatic logic stage_hit(input logic [7:0] a);
    stage_hit = (a[7:6] == motor_pkg::A_STG_HI) && (a[5:4] != 2'h3) && (a[1:0] == 2'h0);
  endfunction

  // stage enables per mode
  always_comb begin
    closed = s.submode[motor_pkg::SUB_LOOP];
    pos_en = closed && (motor_pkg::is_pos_mode(s.op_mode) ||
             (motor_pkg::is_vel_mode(s.op_mode) && s.submode[motor_pkg::SUB_POSVEL]));
    vel_en = closed && !(motor_pkg::is_tq_mode(s.op_mode) &&
             s.submode[motor_pkg::SUB_REALTQ]);
    aff_en = !motor_pkg::is_tq_mode(s.op_mode);
  end

  // parameter set selection: legacy values while bit 0 of the parameter select is one
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      eff[k] = s.psel[0] ? motor_pkg::LEG_STAGE : s.prm[k];
    end
  end

  // feed-forward terms, combined in the same update that uses them
  always_comb begin
    vff_v = pos_en ? motor_pkg::scale(ramp_vel, s.vff_f, 16'h0001) : '0;
    aff_v = aff_en ? motor_pkg::scale(ramp_acc, s.aff_f, s.inertia) : '0;
    sp[motor_pkg::ST_POS]  = ramp_pos;
    act[motor_pkg::ST_POS] = act_pos;
    sp[motor_pkg::ST_VEL]  = pos_en ? y[motor_pkg::ST_POS] + vff_v : ramp_vel;
    act[motor_pkg::ST_VEL] = act_vel;
    sp[motor_pkg::ST_CUR]  = vel_en ? y[motor_pkg::ST_VEL] + aff_v : torque_target;
    act[motor_pkg::ST_CUR] = act_cur;
    if (s.volt_f == 16'h0000 || eff[motor_pkg::ST_CUR][motor_pkg::F_YMAX] == 16'h0000) begin
      volt_v = '0;
    end else begin
      volt_v = motor_pkg::scale(sp[motor_pkg::ST_CUR], s.volt_f, s.rated_v) /
               $signed({16'h0, eff[motor_pkg::ST_CUR][motor_pkg::F_YMAX]});
    end
  end

  // one evaluation per control cycle, outer stage first
  always_comb begin
    start[motor_pkg::ST_POS] = (s.st == motor_pkg::S_POS) && pos_en;
    start[motor_pkg::ST_VEL] = (s.st == motor_pkg::S_VEL) && vel_en;
    start[motor_pkg::ST_CUR] = (s.st == motor_pkg::S_CUR) && closed;
    clr[motor_pkg::ST_POS]   = !pos_en;
    clr[motor_pkg::ST_VEL]   = !vel_en;
    clr[motor_pkg::ST_CUR]   = !closed;
  end

  for (genvar g = 0; g < 3; g++) begin : g_stage
    pi_stage u_pi (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (start[g]),
      .clr     (clr[g]),
      .set_pt  (sp[g]),
      .actual  (act[g]),
      .kp      (eff[g][motor_pkg::F_KP]),
      .tn      (eff[g][motor_pkg::F_TN]),
      .emax    (eff[g][motor_pkg::F_EMAX]),
      .ymax    (eff[g][motor_pkg::F_YMAX]),
      .y       (y[g])
    );
  end

  // register read decode
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = '0;
    if (stage_hit(araddr)) begin
      rd_val = {16'h0, s.prm[araddr[5:4]][araddr[3:2]]};
    end else begin
      unique case (araddr)
        motor_pkg::A_SUBMODE: rd_val = {24'h0, s.submode};
        motor_pkg::A_MODE:    rd_val = {28'h0, s.op_mode};
        motor_pkg::A_PSEL:    rd_val = {30'h0, s.psel};
        motor_pkg::A_VFF:     rd_val = {16'h0, s.vff_f};
        motor_pkg::A_AFF:     rd_val = {16'h0, s.aff_f};
        motor_pkg::A_INERTIA: rd_val = {16'h0, s.inertia};
        motor_pkg::A_VOLTFF:  rd_val = {16'h0, s.volt_f};
        motor_pkg::A_RATEDV:  rd_val = {16'h0, s.rated_v};
        motor_pkg::A_STATUS:  rd_val = {25'h0, s.st, closed, aff_en, vel_en, pos_en};
        motor_pkg::A_PWM:     rd_val = s.pwm;
        default:              rd_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    wr_ok  = stage_hit(s.awa) || (s.awa <= motor_pkg::A_RATEDV && s.awa[1:0] == 2'h0);
    wr_val = merge(32'h0000_0000, s.wd, s.ws);
  end

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    tick = (s.tmr == '0);
    next_s.tmr = tick ? 12'(motor_pkg::CTRL_CYCLES - 1) : s.tmr - 12'h001;
    unique case (s.st)
      motor_pkg::S_IDLE: if (tick) next_s.st = motor_pkg::S_POS;
      motor_pkg::S_POS:  next_s.st = motor_pkg::S_VEL;
      motor_pkg::S_VEL:  next_s.st = motor_pkg::S_CUR;
      motor_pkg::S_CUR:  next_s.st = motor_pkg::S_OUT;
      motor_pkg::S_OUT: begin
        next_s.st   = motor_pkg::S_IDLE;
        next_s.done = 1'b1;
        // voltage feed-forward on top of the current stage, then the pwm limit
        next_s.pwm  = closed ? motor_pkg::sat(80'($signed(y[motor_pkg::ST_CUR])) +
                      80'(volt_v), eff[motor_pkg::ST_CUR][motor_pkg::F_YMAX]) :
                      '0;
      end
      default: next_s.st = motor_pkg::S_IDLE;
    endcase

    // write channel: address and data taken independently
    if (awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awa    = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wd    = wdata;
      next_s.ws    = wstrb;
    end
    if (s.bvalid && bready) next_s.bvalid = 1'b0;
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = wr_ok ? motor_pkg::RESP_OK : motor_pkg::RESP_DEC;
      if (stage_hit(s.awa)) begin
        next_s.prm[s.awa[5:4]][s.awa[3:2]] =
          16'(merge({16'h0, s.prm[s.awa[5:4]][s.awa[3:2]]}, s.wd, s.ws));
      end else begin
        unique case (s.awa)
          motor_pkg::A_SUBMODE: next_s.submode = 8'(merge({24'h0, s.submode}, s.wd, s.ws));
          motor_pkg::A_MODE:    next_s.op_mode = wr_val[3:0];
          motor_pkg::A_PSEL:    next_s.psel = 2'(merge({30'h0, s.psel}, s.wd, s.ws));
          motor_pkg::A_VFF:     next_s.vff_f = 16'(merge({16'h0, s.vff_f}, s.wd, s.ws));
          motor_pkg::A_AFF:     next_s.aff_f = 16'(merge({16'h0, s.aff_f}, s.wd, s.ws));
          motor_pkg::A_INERTIA: next_s.inertia = 16'(merge({16'h0, s.inertia}, s.wd, s.ws));
          motor_pkg::A_VOLTFF:  next_s.volt_f = 16'(merge({16'h0, s.volt_f}, s.wd, s.ws));
          motor_pkg::A_RATEDV:  next_s.rated_v = 16'(merge({16'h0, s.rated_v}, s.wd, s.ws));
          default: ;
        endcase
      end
    end
    // auto setup completion wins over a host write in the same cycle
    if (autoset_done) next_s.submode[motor_pkg::SUB_LOOP] = 1'b1;
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;

    // read channel: data one cycle after the address is taken
    if (s.rvalid && rready) next_s.rvalid = 1'b0;
    if (arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_val;
      next_s.rresp  = rd_ok ? motor_pkg::RESP_OK : motor_pkg::RESP_DEC;
    end
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.psel    <= motor_pkg::RST_PSEL;
      s.volt_f  <= motor_pkg::RST_VOLTFF;
      s.inertia <= motor_pkg::RST_INERTIA;
      s.rated_v <= motor_pkg::RST_RATEDV;
      s.prm     <= {3{motor_pkg::LEG_STAGE}};
    end else begin
      s <= next_s;
    end
  end

  assign awready     = s.awready;
  assign wready      = s.wready;
  assign bvalid      = s.bvalid;
  assign bresp       = s.bresp;
  assign arready     = s.arready;
  assign rvalid      = s.rvalid;
  assign rresp       = s.rresp;
  assign rdata       = s.rdata;
  assign pwm_demand  = s.pwm;
  assign update_done = s.done;

  localparam int DONE_TMR = motor_pkg::CTRL_CYCLES - 5;

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_seq_order: assert property (s.st == motor_pkg::S_POS |=> s.st == motor_pkg::S_VEL
    ##1 s.st == motor_pkg::S_CUR ##1 s.st == motor_pkg::S_OUT ##1 s.done)
    else $error("stage sequence out of order");
  a_cycle_rate: assert property (s.done |-> s.tmr == 12'(DONE_TMR))
    else $error("update not at control cycle rate");
  a_pwm_limit: assert property (s.done |-> (s.pwm <= $signed({16'h0,
    eff[motor_pkg::ST_CUR][motor_pkg::F_YMAX]})))
    else $error("pwm demand above limit");
  a_tq_bypass: assert property ((s.st == motor_pkg::S_CUR && closed && !vel_en)
    |-> sp[motor_pkg::ST_CUR] == torque_target)
    else $error("velocity stage not bypassed");
  a_pos_bypass: assert property ((s.st == motor_pkg::S_VEL && !pos_en)
    |-> sp[motor_pkg::ST_VEL] == ramp_vel)
    else $error("velocity set point wrong without position stage");
  a_aff_torque: assert property ((s.st == motor_pkg::S_CUR && vel_en && !aff_en)
    |-> sp[motor_pkg::ST_CUR] == y[motor_pkg::ST_VEL])
    else $error("acceleration feed-forward in torque mode");
  a_vff_off: assert property ((s.st == motor_pkg::S_OUT && closed && s.volt_f == 16'h0000)
    |=> s.pwm == $past(y[motor_pkg::ST_CUR]))
    else $error("voltage feed-forward not disabled");
  a_autoset_set: assert property (autoset_done |=> s.submode[motor_pkg::SUB_LOOP])
    else $error("auto setup did not set loop select");
  a_open_zero: assert property ((s.st == motor_pkg::S_OUT && !closed) |=> s.pwm == '0)
    else $error("pwm driven in open loop");
  a_legacy_use: assert property (s.psel[0] |-> eff[motor_pkg::ST_VEL] == motor_pkg::LEG_STAGE)
    else $error("legacy set not in use");
  a_b_hold: assert property ((s.bvalid && !bready) |=> s.bvalid && $stable(s.bresp))
    else $error("write response dropped");

  c_closed_update: cover property (closed && pos_en && s.done);
  c_torque_mode: cover property (closed && !vel_en && s.done);
  c_write_done: cover property (s.bvalid && bready);
  c_read_done: cover property (s.rvalid && rready);

endmodule
`default_nettype wire

// *** src/motor_pkg.sv ***
package motor_pkg;

  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned CTRL_PERIOD_US = 50;
  localparam int unsigned CTRL_CYCLES    = CTRL_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int          PERMILLE       = 1000;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_POS  = 3'h1,
    S_VEL  = 3'h3,
    S_CUR  = 3'h2,
    S_OUT  = 3'h6
  } seq_t;

  // stage and parameter field indices
  localparam int ST_POS = 0;
  localparam int ST_VEL = 1;
  localparam int ST_CUR = 2;
  localparam int F_KP   = 0;
  localparam int F_TN   = 1;
  localparam int F_EMAX = 2;
  localparam int F_YMAX = 3;

  // operating modes
  localparam logic [3:0] M_PP  = 4'h1;
  localparam logic [3:0] M_VL  = 4'h2;
  localparam logic [3:0] M_PV  = 4'h3;
  localparam logic [3:0] M_PT  = 4'h4;
  localparam logic [3:0] M_HM  = 4'h6;
  localparam logic [3:0] M_IP  = 4'h7;
  localparam logic [3:0] M_CSP = 4'h8;
  localparam logic [3:0] M_CSV = 4'h9;
  localparam logic [3:0] M_CST = 4'hA;
  localparam logic [3:0] M_CD  = 4'hB;

  // drive submode bits
  localparam int SUB_LOOP   = 0;
  localparam int SUB_POSVEL = 1;
  localparam int SUB_REALTQ = 5;

  // register byte offsets
  localparam logic [7:0] A_SUBMODE = 8'h00;
  localparam logic [7:0] A_MODE    = 8'h04;
  localparam logic [7:0] A_PSEL    = 8'h08;
  localparam logic [7:0] A_VFF     = 8'h0C;
  localparam logic [7:0] A_AFF     = 8'h10;
  localparam logic [7:0] A_INERTIA = 8'h14;
  localparam logic [7:0] A_VOLTFF  = 8'h18;
  localparam logic [7:0] A_RATEDV  = 8'h1C;
  localparam logic [7:0] A_STATUS  = 8'h20;
  localparam logic [7:0] A_PWM     = 8'h24;
  localparam logic [1:0] A_STG_HI  = 2'h1;

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_DEC = 2'h3;

  // reset values; legacy set doubles as the converted new set
  localparam logic [1:0]  RST_PSEL    = 2'h3;
  localparam logic [15:0] RST_VOLTFF  = 16'h03E8;
  localparam logic [15:0] RST_INERTIA = 16'h0001;
  localparam logic [15:0] RST_RATEDV  = 16'h0400;
  localparam logic [15:0] LEG_KP      = 16'h03E8;
  localparam logic [15:0] LEG_TN      = 16'h0064;
  localparam logic [15:0] LEG_EMAX    = 16'h1000;
  localparam logic [15:0] LEG_YMAX    = 16'h1000;
  localparam logic [3:0][15:0] LEG_STAGE = {LEG_YMAX, LEG_EMAX, LEG_TN, LEG_KP};

  function automatic logic signed [31:0] sat(input logic signed [79:0] x,
                                             input logic [15:0] lim);
    logic signed [79:0] l;
    l = $signed({64'h0, lim});
    if (x > l) sat = 32'(l);
    else if (x < -l) sat = 32'(-l);
    else sat = x[31:0];
  endfunction

  function automatic logic signed [31:0] scale(input logic signed [31:0] a,
                                               input logic [15:0] f,
                                               input logic [15:0] g);
    logic signed [79:0] w;
    w = 80'(a) * $signed({64'h0, f}) * $signed({64'h0, g}) / PERMILLE;
    scale = w[31:0];
  endfunction

  function automatic logic is_pos_mode(input logic [3:0] m);
    is_pos_mode = (m == M_PP) || (m == M_HM) || (m == M_IP) || (m == M_CSP) || (m == M_CD);
  endfunction

  function automatic logic is_vel_mode(input logic [3:0] m);
    is_vel_mode = (m == M_VL) || (m == M_PV) || (m == M_CSV);
  endfunction

  function automatic logic is_tq_mode(input logic [3:0] m);
    is_tq_mode = (m == M_PT) || (m == M_CST);
  endfunction

endpackage

// *** src/pi_stage.sv ***
`timescale 1ns/1ps
`default_nettype none
module pi_stage (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // sequencing
  input  wire logic               start,
  input  wire logic               clr,
  // operands
  input  wire logic signed [31:0] set_pt,
  input  wire logic signed [31:0] actual,
  input  wire logic        [15:0] kp,
  input  wire logic        [15:0] tn,
  input  wire logic        [15:0] emax,
  input  wire logic        [15:0] ymax,
  // control variable
  output logic signed      [31:0] y
);

  typedef struct packed {
    logic signed [31:0] integ;
    logic signed [31:0] y;
  } pi_state_t;

  pi_state_t          s;
  pi_state_t          next_s;
  logic signed [79:0] e;
  logic signed [79:0] p;
  logic signed [79:0] den;

  always_comb begin
    next_s = s;
    e   = 80'(set_pt) - 80'(actual);
    den = $signed({64'h0, (emax == 16'h0000) ? 16'h0001 : emax}) * motor_pkg::PERMILLE;
    // gain in per mille: e == emax at 1000 gives exactly ymax
    p = e * $signed({64'h0, kp}) * $signed({64'h0, ymax}) / den;
    if (clr) begin
      next_s = '0;
    end else if (start) begin
      // shorter reset time integrates faster; zero means proportional only
      if (tn == 16'h0000) begin
        next_s.integ = '0;
      end else begin
        next_s.integ = motor_pkg::sat(80'(s.integ) + p / $signed({64'h0, tn}), ymax);
      end
      next_s.y = motor_pkg::sat(p + 80'(next_s.integ), ymax);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) s <= '0;
    else s <= next_s;
  end

  assign y = s.y;

endmodule
`default_nettype wire
